// >>> status_pkg.sv
/*
 * Constants, field layout and carrier types of the instrument status
 * register bank.
 * Assumes one synchronous clock and a command parser that issues
 * register commands and condition strobes in that clock domain.
 */
`default_nettype none

package status_pkg;

	// -----------------------------------------------------------
	// register select
	// -----------------------------------------------------------
	localparam logic [2:0] SET_FREQ  = 3'h0;
	localparam logic [2:0] SET_POWER = 3'h1;
	localparam logic [2:0] SET_STD   = 3'h2;
	localparam logic [2:0] SET_OPER  = 3'h3;
	localparam logic [2:0] SET_USER  = 3'h4;
	localparam int         NUM_SETS  = 5;

	localparam logic [2:0] FLD_COND = 3'h0;
	localparam logic [2:0] FLD_PTR  = 3'h1;
	localparam logic [2:0] FLD_NTR  = 3'h2;
	localparam logic [2:0] FLD_EVT  = 3'h3;
	localparam logic [2:0] FLD_EN   = 3'h4;

	// -----------------------------------------------------------
	// bit positions
	// -----------------------------------------------------------
	localparam int FQ_SPAN  = 0;
	localparam int FQ_LO    = 1;
	localparam int FQ_REF   = 2;
	localparam int PW_OVLD  = 0;
	localparam int PW_OVSW  = 1;
	localparam int PW_INTRP = 2;
	localparam int PW_SRTRP = 3;
	localparam int PW_ADC   = 4;
	localparam int SE_OPC   = 0;
	localparam int SE_REQ   = 1;
	localparam int SE_QRY   = 2;
	localparam int SE_DEV   = 3;
	localparam int SE_EXE   = 4;
	localparam int SE_CMD   = 5;
	localparam int SE_PON   = 7;
	localparam int OP_CAL   = 0;
	localparam int OP_SETL  = 1;
	localparam int OP_RANGE = 2;
	localparam int OP_SWEEP = 3;
	localparam int OP_MEAS  = 4;
	localparam int OP_TRIG  = 5;
	localparam int OP_ARM   = 6;
	localparam int OP_AVG   = 8;
	localparam int OP_PROG  = 14;
	localparam int QD_POWER = 3;
	localparam int QD_FREQ  = 5;
	localparam int SB_USER  = 0;
	localparam int SB_STD   = 5;
	localparam int SB_OPER  = 7;

	// -----------------------------------------------------------
	// reset values and masks
	// -----------------------------------------------------------
	localparam logic [15:0] ZERO16   = 16'h0000;
	localparam logic [15:0] ONES16   = 16'hffff;
	localparam logic [15:0] PTR_RST  = 16'hffff;
	localparam logic [15:0] NTR_RST  = 16'h0000;
	localparam logic [15:0] EVT_RST  = 16'h0000;
	localparam logic [15:0] STD_RST  = 16'h0080;
	localparam logic [15:0] EN_RST   = 16'h0000;
	localparam logic [15:0] STD_MASK = 16'h00ff;

	// -----------------------------------------------------------
	// carriers
	// -----------------------------------------------------------
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [2:0]  set;
		logic [2:0]  fld;
		logic [15:0] wdata;
	} reg_cmd_s;

	typedef struct packed {
		logic span_uncal;
		logic lo_unlock;
		logic ref_unlock;
		logic in_ovld;
		logic oversweep;
		logic in_trip;
		logic src_trip;
		logic adc_ovld;
		logic opc_cmd;
		logic ops_done;
		logic addr_only;
		logic need_ctrl;
		logic query_err;
		logic dev_err;
		logic exec_err;
		logic cmd_err;
		logic calibrating;
		logic settling;
		logic ranging;
		logic sweeping;
		logic measuring;
		logic trig_ready;
		logic arm_manual;
		logic arm_ready;
		logic video_average_selection;
		logic average_enable_command;
		logic prog_running;
	} cond_in_s;

endpackage : status_pkg

`default_nettype wire

// >>> instrument_status_registers.sv
/*
 * Status register bank: five condition/event/enable sets, summaries,
 * trigger and arm gating.
 * Assumes every input is synchronous to i_clk_sys and one command
 * per cycle at most on i_cmd.
 */
`default_nettype none

module instrument_status_registers
	import status_pkg::*;
(
	input  wire logic     i_clk_sys,
	input  wire logic     i_rst,
	input  wire logic     i_ce,
	input  wire reg_cmd_s i_cmd,
	input  wire logic     i_clear_all,
	input  wire cond_in_s i_cond,
	input  wire logic [15:0] i_user_key,
	input  wire logic     i_trigger,
	input  wire logic     i_immediate_arm_command,
	output logic [15:0]   o_rd_data,
	output logic          o_rd_valid,
	output logic [15:0]   o_quest_sum,
	output logic [7:0]    o_stb_sum,
	output logic          o_trig_accept,
	output logic          o_arm_accept
);

	// -----------------------------------------------------------
	// helpers
	// -----------------------------------------------------------
	function automatic logic [15:0] latch_evt(
		input logic [15:0] evt,
		input logic [15:0] cur,
		input logic [15:0] nxt,
		input logic [15:0] ptr,
		input logic [15:0] ntr,
		input logic [15:0] clr
	);
		// set wins over a clear in the same cycle
		latch_evt = (evt & ~clr) | (ptr & nxt & ~cur)
			| (ntr & ~nxt & cur);
	endfunction : latch_evt

	function automatic logic full_set(input logic [2:0] s);
		full_set = (s == SET_FREQ) || (s == SET_POWER)
			|| (s == SET_OPER);
	endfunction : full_set

	// -----------------------------------------------------------
	// state
	// -----------------------------------------------------------
	logic [15:0] cond [NUM_SETS];
	logic [15:0] ptr  [NUM_SETS];
	logic [15:0] ntr  [NUM_SETS];
	logic [15:0] evt  [NUM_SETS];
	logic [15:0] en   [NUM_SETS];
	logic        opc_armed;

	logic [15:0] next_cond [NUM_SETS];
	logic [15:0] eff_ptr   [NUM_SETS];
	logic [15:0] eff_ntr   [NUM_SETS];
	logic [15:0] clr       [NUM_SETS];
	logic [15:0] next_evt  [NUM_SETS];

	// -----------------------------------------------------------
	// command decode
	// -----------------------------------------------------------
	wire logic set_ok  = i_cmd.set <= SET_USER;
	wire logic is_full = full_set(i_cmd.set);
	wire logic is_std  = i_cmd.set == SET_STD;
	wire logic is_user = i_cmd.set == SET_USER;
	wire logic wr_trans = i_cmd.wr && is_full
		&& (i_cmd.fld == FLD_PTR || i_cmd.fld == FLD_NTR);
	wire logic wr_en = i_cmd.wr && set_ok
		&& i_cmd.fld == FLD_EN;
	wire logic wr_user = i_cmd.wr && is_user
		&& i_cmd.fld == FLD_COND;
	wire logic rd_evt = i_cmd.rd && set_ok
		&& i_cmd.fld == FLD_EVT;
	// user condition and all std fields other than evt/en unreadable
	wire logic rd_ok = i_cmd.rd && set_ok && (is_full
		|| i_cmd.fld == FLD_EVT || i_cmd.fld == FLD_EN);
	wire logic [15:0] wmask = is_std ? STD_MASK : ONES16;

	logic [15:0] rd_mux;
	always_comb begin
		rd_mux = ZERO16;
		if (rd_ok) begin
			unique case (i_cmd.fld)
				FLD_COND: rd_mux = cond[i_cmd.set];
				FLD_PTR:  rd_mux = ptr[i_cmd.set];
				FLD_NTR:  rd_mux = ntr[i_cmd.set];
				FLD_EVT:  rd_mux = evt[i_cmd.set];
				FLD_EN:   rd_mux = en[i_cmd.set];
				default:  rd_mux = ZERO16;
			endcase
		end
	end

	// -----------------------------------------------------------
	// condition sources
	// -----------------------------------------------------------
	wire logic opc_fire = opc_armed && i_cond.ops_done;

	always_comb begin
		for (int s = 0; s < NUM_SETS; s++) begin
			next_cond[s] = ZERO16;
		end
		next_cond[SET_FREQ][FQ_SPAN] = i_cond.span_uncal;
		next_cond[SET_FREQ][FQ_LO] = i_cond.lo_unlock;
		next_cond[SET_FREQ][FQ_REF] = i_cond.ref_unlock;
		// overload is flagged upstream for inputs under 150 MHz
		next_cond[SET_POWER][PW_OVLD] = i_cond.in_ovld;
		next_cond[SET_POWER][PW_OVSW] = i_cond.oversweep;
		next_cond[SET_POWER][PW_INTRP] = i_cond.in_trip;
		next_cond[SET_POWER][PW_SRTRP] = i_cond.src_trip;
		next_cond[SET_POWER][PW_ADC] = i_cond.adc_ovld;
		next_cond[SET_STD][SE_OPC] = opc_fire;
		next_cond[SET_STD][SE_REQ] =
			i_cond.addr_only && i_cond.need_ctrl;
		next_cond[SET_STD][SE_QRY] = i_cond.query_err;
		next_cond[SET_STD][SE_DEV] = i_cond.dev_err;
		next_cond[SET_STD][SE_EXE] = i_cond.exec_err;
		next_cond[SET_STD][SE_CMD] = i_cond.cmd_err;
		next_cond[SET_OPER][OP_CAL] = i_cond.calibrating;
		next_cond[SET_OPER][OP_SETL] = i_cond.settling;
		next_cond[SET_OPER][OP_RANGE] = i_cond.ranging;
		next_cond[SET_OPER][OP_SWEEP] = i_cond.sweeping;
		next_cond[SET_OPER][OP_MEAS] = i_cond.measuring;
		next_cond[SET_OPER][OP_TRIG] = i_cond.trig_ready;
		next_cond[SET_OPER][OP_ARM] =
			i_cond.arm_manual && i_cond.arm_ready;
		next_cond[SET_OPER][OP_AVG] = i_cond.video_average_selection
			&& i_cond.average_enable_command;
		next_cond[SET_OPER][OP_PROG] = i_cond.prog_running;
		// one-cycle pulse per set bit, rest at zero
		next_cond[SET_USER] = i_user_key
			| (wr_user ? i_cmd.wdata : ZERO16);
	end

	// -----------------------------------------------------------
	// event latching
	// -----------------------------------------------------------
	always_comb begin
		for (int s = 0; s < NUM_SETS; s++) begin
			eff_ptr[s] = ptr[s];
			eff_ntr[s] = ntr[s];
			clr[s] = (i_clear_all || (rd_evt
				&& i_cmd.set == 3'(s))) ? ONES16 : ZERO16;
		end
		eff_ptr[SET_STD] = ONES16;
		eff_ntr[SET_STD] = ZERO16;
		eff_ptr[SET_USER] = ONES16;
		eff_ntr[SET_USER] = ZERO16;
		for (int s = 0; s < NUM_SETS; s++) begin
			next_evt[s] = latch_evt(evt[s], cond[s], next_cond[s],
				eff_ptr[s], eff_ntr[s], clr[s]);
		end
	end

	// -----------------------------------------------------------
	// summaries
	// -----------------------------------------------------------
	wire logic sum_power = |(evt[SET_POWER] & en[SET_POWER]);
	wire logic sum_freq  = |(evt[SET_FREQ] & en[SET_FREQ]);
	wire logic sum_std   = |(evt[SET_STD] & en[SET_STD]);
	wire logic sum_oper  = |(evt[SET_OPER] & en[SET_OPER]);
	wire logic sum_user  = |(evt[SET_USER] & en[SET_USER]);

	logic [15:0] next_quest;
	logic [7:0]  next_stb;
	always_comb begin
		next_quest = ZERO16;
		next_stb = 8'h00;
		next_quest[QD_POWER] = sum_power;
		next_quest[QD_FREQ] = sum_freq;
		next_stb[SB_USER] = sum_user;
		next_stb[SB_STD] = sum_std;
		next_stb[SB_OPER] = sum_oper;
	end

	// -----------------------------------------------------------
	// registers
	// -----------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			for (int s = 0; s < NUM_SETS; s++) begin
				cond[s] <= ZERO16;
				ptr[s] <= PTR_RST;
				ntr[s] <= NTR_RST;
				evt[s] <= EVT_RST;
				en[s] <= EN_RST;
			end
			evt[SET_STD] <= STD_RST;
			opc_armed <= 1'b0;
		end else if (i_ce) begin
			for (int s = 0; s < NUM_SETS; s++) begin
				cond[s] <= next_cond[s];
				evt[s] <= next_evt[s];
			end
			if (wr_trans && i_cmd.fld == FLD_PTR)
				ptr[i_cmd.set] <= i_cmd.wdata;
			if (wr_trans && i_cmd.fld == FLD_NTR)
				ntr[i_cmd.set] <= i_cmd.wdata;
			if (wr_en)
				en[i_cmd.set] <= i_cmd.wdata & wmask;
			// a new request re-arms even as an old one completes
			opc_armed <= i_cond.opc_cmd
				|| (opc_armed && !i_cond.ops_done);
		end
	end

	// -----------------------------------------------------------
	// outputs
	// -----------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_rd_data <= ZERO16;
			o_rd_valid <= 1'b0;
			o_quest_sum <= ZERO16;
			o_stb_sum <= 8'h00;
			o_trig_accept <= 1'b0;
			o_arm_accept <= 1'b0;
		end else if (i_ce) begin
			o_rd_data <= rd_mux;
			o_rd_valid <= i_cmd.rd;
			o_quest_sum <= next_quest;
			o_stb_sum <= next_stb;
			// condition flop is the ready state already reported
			o_trig_accept <= i_trigger && cond[SET_OPER][OP_TRIG];
			o_arm_accept <= i_immediate_arm_command && cond[SET_OPER][OP_ARM];
		end
	end

	// -----------------------------------------------------------
	// assertions
	// -----------------------------------------------------------
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst || !i_ce);

	AST_FQ_LO: assert property (
		i_cond.lo_unlock |=> cond[SET_FREQ][FQ_LO]
	) else $error("lo unlock not reported");

	AST_STD_CMD: assert property (
		i_cond.cmd_err && !cond[SET_STD][SE_CMD]
		|=> evt[SET_STD][SE_CMD]
	) else $error("command error not latched");

	AST_OPC: assert property (
		$rose(evt[SET_STD][SE_OPC]) |-> $past(opc_armed)
	) else $error("opc event without request");

	AST_PON: assert property (
		$fell(i_rst) |-> evt[SET_STD][SE_PON]
	) else $error("power on bit missing");

	AST_TRIG: assert property (
		o_trig_accept |-> $past(cond[SET_OPER][OP_TRIG])
	) else $error("trigger accepted while not ready");

	AST_ARM: assert property (
		i_immediate_arm_command && !cond[SET_OPER][OP_ARM] |=> !o_arm_accept
	) else $error("arm accepted while not ready");

	AST_AVG: assert property (
		i_cond.video_average_selection
		&& i_cond.average_enable_command
		|=> cond[SET_OPER][OP_AVG]
	) else $error("averaging bit not set");

	AST_USER32: assert property (
		wr_user && i_cmd.wdata == 16'h0020 && i_user_key == ZERO16
		|=> cond[SET_USER] == 16'h0020
	) else $error("user pulse on wrong bit");

	AST_STB_STD: assert property (
		sum_std |=> o_stb_sum[SB_STD]
	) else $error("standard event summary missing");

	AST_HOLD: assert property (
		evt[SET_FREQ][FQ_SPAN] && !i_clear_all && !rd_evt
		|=> evt[SET_FREQ][FQ_SPAN]
	) else $error("event bit lost");

	AST_FQ_SPAN: assert property (
		i_cond.span_uncal |=> cond[SET_FREQ][FQ_SPAN]
	) else $error("span uncalibrated not reported");

	AST_FQ_REF: assert property (
		i_cond.ref_unlock |=> cond[SET_FREQ][FQ_REF]
	) else $error("reference unlock not reported");

	AST_PW_OVLD: assert property (
		i_cond.in_ovld |=> cond[SET_POWER][PW_OVLD]
	) else $error("input overload not reported");

	AST_PW_OVSW: assert property (
		i_cond.oversweep |=> cond[SET_POWER][PW_OVSW]
	) else $error("oversweep not reported");

	AST_PW_INTRP: assert property (
		i_cond.in_trip |=> cond[SET_POWER][PW_INTRP]
	) else $error("input relay trip not reported");

	AST_PW_SRTRP: assert property (
		i_cond.src_trip |=> cond[SET_POWER][PW_SRTRP]
	) else $error("source relay trip not reported");

	AST_PW_ADC: assert property (
		i_cond.adc_ovld |=> cond[SET_POWER][PW_ADC]
	) else $error("converter overload not reported");

	AST_STD_NOFALL: assert property (
		cond[SET_STD][SE_EXE] && !i_cond.exec_err
		&& !evt[SET_STD][SE_EXE] |=> !evt[SET_STD][SE_EXE]
	) else $error("falling standard condition latched");

	AST_STD_REQ: assert property (
		i_cond.addr_only && i_cond.need_ctrl |=> cond[SET_STD][SE_REQ]
	) else $error("request control not reported");

	AST_STD_QRY: assert property (
		i_cond.query_err |=> cond[SET_STD][SE_QRY]
	) else $error("query error not reported");

	AST_STD_EXE: assert property (
		i_cond.exec_err |=> cond[SET_STD][SE_EXE]
	) else $error("execution error not reported");

	AST_OP_CAL: assert property (
		i_cond.calibrating |=> cond[SET_OPER][OP_CAL]
	) else $error("calibrating not reported");

	AST_OP_RANGE: assert property (
		i_cond.ranging |=> cond[SET_OPER][OP_RANGE]
	) else $error("ranging not reported");

	AST_OP_SWEEP: assert property (
		i_cond.sweeping |=> cond[SET_OPER][OP_SWEEP]
	) else $error("sweeping not reported");

	AST_OP_MEAS: assert property (
		i_cond.measuring |=> cond[SET_OPER][OP_MEAS]
	) else $error("measuring not reported");

	AST_OP_PROG: assert property (
		i_cond.prog_running |=> cond[SET_OPER][OP_PROG]
	) else $error("program running not reported");

	AST_USER_HIDDEN: assert property (
		i_cmd.rd && i_cmd.set == SET_USER && i_cmd.fld != FLD_EVT
		&& i_cmd.fld != FLD_EN |=> o_rd_data == ZERO16
	) else $error("user hidden field readable");

	AST_USER_RISE: assert property (
		(i_user_key & ~cond[SET_USER]) != ZERO16 |=> evt[SET_USER] != ZERO16
	) else $error("user rise not latched");

	AST_USER_REST: assert property (
		!wr_user && i_user_key == ZERO16 |=> cond[SET_USER] == ZERO16
	) else $error("user condition not at rest");

	AST_QD_FREQ: assert property (
		sum_freq |=> o_quest_sum[QD_FREQ]
	) else $error("frequency summary missing");

	AST_STB_OPER: assert property (
		sum_oper |=> o_stb_sum[SB_OPER]
	) else $error("operation summary missing");

	AST_EVT_CLR: assert property (
		(i_clear_all || (rd_evt && i_cmd.set == SET_FREQ)) && !i_cond.span_uncal
		&& !cond[SET_FREQ][FQ_SPAN] |=> !evt[SET_FREQ][FQ_SPAN]
	) else $error("event bit not cleared");

	AST_RST_CLR: assert property (
		$fell(i_rst) |-> en[SET_STD] == EN_RST && evt[SET_FREQ] == EVT_RST
	) else $error("reset left state behind");

	COV_OPC: cover property ($rose(evt[SET_STD][SE_OPC]));
	COV_TRIG: cover property (o_trig_accept);
	COV_USER: cover property (wr_user ##1 evt[SET_USER] != ZERO16);
	COV_STB: cover property (o_stb_sum[SB_STD] && o_stb_sum[SB_OPER]);
	COV_ARM: cover property (o_arm_accept);

endmodule : instrument_status_registers

`default_nettype wire

// >>> status_partner.sv
/*
 * Far-side model: measurement subsystems and command parser raising conditions.
 * Assumes the bench posts the wanted levels just after a rising clock edge.
 */
`default_nettype none

module status_partner
	import status_pkg::*;
(
	input  wire logic     i_clk_sys,
	input  wire cond_in_s i_req,
	output var  cond_in_s o_cond
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// condition sources
	// ----------------------------------------
	// sources launch on the edge, like registered subsystem flags
	initial o_cond = '0;
	always @(posedge i_clk_sys) begin
		o_cond <= i_req;
	end
endmodule : status_partner

`default_nettype wire

// >>> tb_instrument_status_registers.sv
/*
 * Self-checking bench of the status register bank.
 * Assumes status_pkg and the far-side model status_partner.
 */
`default_nettype none

module tb_instrument_status_registers;
	timeunit 1ns;
	timeprecision 1ps;
	import status_pkg::*;

	typedef struct {
		cond_in_s    m;
		logic [2:0]  s;
		logic [2:0]  f;
		logic [15:0] e;
	} row_s;

	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        ce = 1'b1;
	logic        clear_all = 1'b0;
	logic        trigger = 1'b0;
	logic        immediate_arm_command = 1'b0;
	logic [15:0] user_key = 16'h0000;
	reg_cmd_s    cmd = '0;
	cond_in_s    req = '0;
	cond_in_s    cond;
	logic [15:0] rd_data;
	logic        rd_valid;
	logic [15:0] quest_sum;
	logic [7:0]  stb_sum;
	logic        trig_accept;
	logic        arm_accept;
	int          err_count = 0;
	int          checks_done = 0;

	// ----------------------------------------
	// ordinary cases: one condition bit each
	// ----------------------------------------
	row_s rows [0:21] = '{
		'{27'h4000000, SET_FREQ, FLD_COND, 16'h0001},
		'{27'h2000000, SET_FREQ, FLD_COND, 16'h0002},
		'{27'h1000000, SET_FREQ, FLD_COND, 16'h0004},
		'{27'h0800000, SET_POWER, FLD_COND, 16'h0001},
		'{27'h0400000, SET_POWER, FLD_COND, 16'h0002},
		'{27'h0200000, SET_POWER, FLD_COND, 16'h0004},
		'{27'h0100000, SET_POWER, FLD_COND, 16'h0008},
		'{27'h0080000, SET_POWER, FLD_COND, 16'h0010},
		'{27'h0018000, SET_STD, FLD_EVT, 16'h0002},
		'{27'h0004000, SET_STD, FLD_EVT, 16'h0004},
		'{27'h0002000, SET_STD, FLD_EVT, 16'h0008},
		'{27'h0001000, SET_STD, FLD_EVT, 16'h0010},
		'{27'h0000800, SET_STD, FLD_EVT, 16'h0020},
		'{27'h0000400, SET_OPER, FLD_COND, 16'h0001},
		'{27'h0000200, SET_OPER, FLD_COND, 16'h0002},
		'{27'h0000100, SET_OPER, FLD_COND, 16'h0004},
		'{27'h0000080, SET_OPER, FLD_COND, 16'h0008},
		'{27'h0000040, SET_OPER, FLD_COND, 16'h0010},
		'{27'h0000020, SET_OPER, FLD_COND, 16'h0020},
		'{27'h0000018, SET_OPER, FLD_COND, 16'h0040},
		'{27'h0000006, SET_OPER, FLD_COND, 16'h0100},
		'{27'h0000001, SET_OPER, FLD_COND, 16'h4000}
	};

	status_partner far_side (
		.i_clk_sys (clk_sys),
		.i_req     (req),
		.o_cond    (cond)
	);

	instrument_status_registers dut (
		.i_clk_sys     (clk_sys),
		.i_rst         (rst),
		.i_ce          (ce),
		.i_cmd         (cmd),
		.i_clear_all   (clear_all),
		.i_cond        (cond),
		.i_user_key    (user_key),
		.i_trigger     (trigger),
		.i_immediate_arm_command     (immediate_arm_command),
		.o_rd_data     (rd_data),
		.o_rd_valid    (rd_valid),
		.o_quest_sum   (quest_sum),
		.o_stb_sum     (stb_sum),
		.o_trig_accept (trig_accept),
		.o_arm_accept  (arm_accept)
	);

	always #4 clk_sys = ~clk_sys;

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic rd(input logic [2:0] s, input logic [2:0] f, input logic [15:0] exp);
		cmd = '{1'b1, 1'b0, s, f, 16'h0000};
		tick(1);
		cmd = '0;
		chk("rd_valid", 16'h0001, {15'h0000, rd_valid});
		chk("rd_data", exp, rd_data);
		// idle edge between commands
		tick(1);
	endtask : rd

	task automatic wr(input logic [2:0] s, input logic [2:0] f, input logic [15:0] d);
		cmd = '{1'b0, 1'b1, s, f, d};
		tick(1);
		cmd = '0;
		tick(1);
	endtask : wr

	// one-cycle request from the far side, then settle
	task automatic pulse(input cond_in_s m);
		req = m;
		tick(1);
		req = '0;
		tick(4);
	endtask : pulse

	task automatic conclude();
		if (err_count == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude

	initial begin
		#16000;
		err_count++;
		conclude();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		tick(2);
		rst = 1'b0;
		rd(SET_STD, FLD_EVT, 16'h0080);
		rd(SET_STD, FLD_EVT, 16'h0000);
		rd(SET_STD, FLD_EN, 16'h0000);
		rd(SET_OPER, FLD_PTR, 16'hffff);
		foreach (rows[i]) begin
			req = rows[i].m;
			tick(3);
			rd(rows[i].s, rows[i].f, rows[i].e);
			req = '0;
			tick(2);
		end
		// awkward cases: access kinds and refusals
		wr(SET_STD, FLD_EN, 16'hffff);
		rd(SET_STD, FLD_EN, 16'h00ff);
		wr(SET_FREQ, FLD_COND, 16'hffff);
		rd(SET_FREQ, FLD_COND, 16'h0000);
		rd(3'h5, FLD_COND, 16'h0000);
		rd(SET_USER, FLD_COND, 16'h0000);
		// user pulses, transitions fixed even after a write attempt
		wr(SET_USER, FLD_PTR, 16'h0000);
		wr(SET_USER, FLD_COND, 16'h0020);
		tick(2);
		rd(SET_USER, FLD_EVT, 16'h0020);
		user_key = 16'h0008;
		tick(1);
		user_key = 16'h0000;
		tick(2);
		rd(SET_USER, FLD_EVT, 16'h0008);
		rd(SET_USER, FLD_EVT, 16'h0000);
		// completion only counts after the command was seen first
		pulse(27'h0020000);
		rd(SET_STD, FLD_EVT, 16'h0000);
		pulse(27'h0060000);
		rd(SET_STD, FLD_EVT, 16'h0000);
		pulse(27'h0020000);
		rd(SET_STD, FLD_EVT, 16'h0001);
		// summaries
		clear_all = 1'b1;
		tick(1);
		clear_all = 1'b0;
		wr(SET_STD, FLD_EN, 16'h0020);
		wr(SET_OPER, FLD_EN, 16'h0004);
		wr(SET_FREQ, FLD_EN, 16'h0002);
		wr(SET_POWER, FLD_EN, 16'h0010);
		pulse(27'h2080900);
		chk("stb_sum", 16'h00a0, {8'h00, stb_sum});
		chk("quest_sum", 16'h0028, quest_sum);
		rd(SET_STD, FLD_EVT, 16'h0020);
		pulse(27'h0001000);
		chk("stb_sum", 16'h0080, {8'h00, stb_sum});
		// trigger and arm only once ready was reported
		trigger = 1'b1;
		immediate_arm_command = 1'b1;
		tick(1);
		trigger = 1'b0;
		immediate_arm_command = 1'b0;
		chk("trig_accept", 16'h0000, {15'h0000, trig_accept});
		chk("arm_accept", 16'h0000, {15'h0000, arm_accept});
		req = 27'h0000038;
		tick(3);
		trigger = 1'b1;
		tick(1);
		trigger = 1'b0;
		chk("trig_accept", 16'h0001, {15'h0000, trig_accept});
		immediate_arm_command = 1'b1;
		tick(1);
		immediate_arm_command = 1'b0;
		chk("arm_accept", 16'h0001, {15'h0000, arm_accept});
		// a key pulse while frozen must leave no trace
		ce = 1'b0;
		user_key = 16'h0001;
		tick(1);
		user_key = 16'h0000;
		ce = 1'b1;
		rd(SET_USER, FLD_EVT, 16'h0000);
		// second reset in mid-run
		rst = 1'b1;
		tick(1);
		rst = 1'b0;
		rd(SET_STD, FLD_EVT, 16'h0080);
		rd(SET_STD, FLD_EN, 16'h0000);
		conclude();
	end
endmodule : tb_instrument_status_registers

`default_nettype wire
